// file: hdl/stb_beat.sv
// Beat counter and byte lane checker for one data tenure
`timescale 1ns/100ps
module stb_beat
    import stb_pkg::*;
(
    // Clock
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    // Control
    input  wire logic                      start,
    input  wire logic                      burst,
    input  wire logic                      beat_ack,
    input  wire logic [STB_ADDR_W-1:0]     addr,
    input  wire logic [3:0]                nbytes,
    // Status
    output logic      [STB_BEAT_CNT_W-1:0] beat_idx,
    output logic                           last,
    output logic      [STB_BE_W-1:0]       lane_mask,
    output logic                           fits
);
    logic [STB_BEAT_CNT_W-1:0] cnt_r;
    logic [STB_BEAT_CNT_W-1:0] cnt_nxt;
    logic [4:0]                end_byte;

    assign cnt_nxt  = start ? '0 : (beat_ack ? cnt_r + 1'b1 : cnt_r);
    assign beat_idx = cnt_r;
    // One beat per acknowledge, so a full-rate target streams every clock
    assign last     = !burst || (cnt_r == STB_BEAT_CNT_W'(STB_BURST_BEATS-1)); // [RULE9] [RULE10]
    assign end_byte = 5'(addr[2:0]) + 5'(nbytes);
    assign fits     = burst ? (addr[STB_SECTOR_LSB-1:0] == '0)
                            : (nbytes != 4'h0 && end_byte <= 5'h08); // [RULE8]
    assign lane_mask = burst ? 8'hFF
                     : 8'((16'h00FF >> (5'h08 - 5'(nbytes))) << addr[2:0]);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else if (clk_en)
            cnt_r <= cnt_nxt;
    end
endmodule // stb_beat

// file: hdl/stb_master.sv
// Split tenure bus master: address and data tenure sequencing
`timescale 1ns/100ps
module stb_master
    import stb_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    // Core request
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire stb_pkg::stb_rkind_t     req_kind,
    input  wire logic [31:0]             req_addr,
    input  wire logic [3:0]              req_nbytes,
    input  wire logic                    req_burst,
    input  wire logic                    req_dstore,
    input  wire stb_pkg::stb_cstate_t    req_cstate,
    input  wire logic                    req_mei,
    // Core write data and read return
    input  wire logic [63:0]             wr_data,
    output logic                         wr_pop,
    output logic [63:0]                  rd_data,
    output logic                         rd_valid,
    output logic                         done,
    output logic                         err,
    // Address bus
    output logic                         abr_req,
    input  wire logic                    abus_grant,
    output logic                         a_start,
    output logic [31:0]                  a_addr,
    output logic [2:0]                   a_tt,
    output logic [7:0]                   a_lanes,
    output logic                         a_burst,
    output logic                         a_oe,
    input  wire logic                    a_ack,
    input  wire logic                    a_rerun,
    // Data bus
    output logic                         dbr_req,
    input  wire logic                    dbus_grant,
    output logic [63:0]                  d_out,
    output logic                         d_oe,
    input  wire logic [63:0]             d_in,
    input  wire logic                    d_ack,
    input  wire logic                    d_retry,
    // Extended protocol reply
    input  wire logic                    x_reply,
    input  wire logic                    x_reply_ok
);
    import stb_pkg::*;

    // ********************************************************
    // States
    // ********************************************************
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_AARB  = 7'h02,
        ST_AXFR  = 7'h04,
        ST_AEND  = 7'h08,
        ST_DARB  = 7'h10,
        ST_DXFR  = 7'h20,
        ST_XWAIT = 7'h40
    } stb_state_t;

    stb_state_t       st_r;
    stb_state_t       st_nxt;
    logic [31:0]      addr_r;
    logic [2:0]       tt_r;
    logic [3:0]       nb_r;
    logic             burst_r;
    logic             wr_r;
    logic             adonly_r;
    logic             xpr_r;
    logic [63:0]      rd_data_r;
    logic             rd_valid_r;
    logic             done_r;
    logic             err_r;
    logic             dstart;
    logic             blast;
    logic [7:0]       lanes;
    logic             fits;
    logic             take;
    logic             beat_ok;
    logic [2:0]       tt_sel;
    logic             need_claim;

    // ********************************************************
    // Decode
    // ********************************************************
    // Missing sector on read or write, or shared sector on write, broadcasts
    // A three-state cache has no shared state, so only a miss claims there
    assign need_claim = (req_kind == STB_RK_READ && req_cstate == STB_CS_INV)
        || (req_kind == STB_RK_WRITE && (req_cstate == STB_CS_INV
            || (req_cstate == STB_CS_SHR && !req_mei))); // [RULE6] [RULE7]
    assign tt_sel = req_dstore ? (req_kind == STB_RK_WRITE ? STB_TT_XWRITE
                                                           : STB_TT_XREAD)
        : (req_kind == STB_RK_ADONLY) ? STB_TT_ADONLY
        : (req_kind == STB_RK_WRITE && need_claim) ? STB_TT_RWITM
        : (req_kind == STB_RK_WRITE) ? STB_TT_WRITE : STB_TT_READ; // [RULE11]
    assign req_ready = (st_r == ST_IDLE);
    assign take      = req_valid && req_ready;
    // Data tenure may only open once the address transfer is under way
    assign dstart    = (st_r == ST_AEND) && a_ack && !a_rerun && !adonly_r; // [RULE18]
    assign beat_ok   = (st_r == ST_DXFR) && d_ack && !d_retry;

    stb_beat u_beat (
        .core_clk  (core_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .start     (dstart || ((st_r == ST_DXFR) && d_retry)),
        .burst     (burst_r),
        .beat_ack  (beat_ok),
        .addr      (addr_r),
        .nbytes    (nb_r),
        .beat_idx  (),
        .last      (blast),
        .lane_mask (lanes),
        .fits      (fits)
    );

    // ********************************************************
    // Sequencer
    // ********************************************************
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:  if (take) st_nxt = ST_AARB;
            // Parked grant lets the tenure start the next cycle
            ST_AARB:  if (abus_grant) st_nxt = ST_AXFR; // [RULE3] [RULE4] [RULE12]
            ST_AXFR:  st_nxt = ST_AEND;
            ST_AEND:
                if (a_ack && a_rerun) st_nxt = ST_AARB; // [RULE14]
                else if (a_ack && adonly_r) st_nxt = ST_IDLE; // [RULE17]
                else if (a_ack) st_nxt = ST_DARB;
            ST_DARB:  if (dbus_grant) st_nxt = ST_DXFR; // [RULE12]
            ST_DXFR:
                if (d_ack && d_retry) st_nxt = ST_DARB; // [RULE16]
                else if (beat_ok && blast)
                    st_nxt = xpr_r ? ST_XWAIT : ST_IDLE;
            ST_XWAIT: if (x_reply) st_nxt = ST_IDLE; // [RULE11]
            default:  st_nxt = ST_IDLE;
        endcase
    end

    // ********************************************************
    // Bus outputs
    // ********************************************************
    assign abr_req = (st_r == ST_AARB);
    assign a_oe    = (st_r == ST_AXFR) || (st_r == ST_AEND); // [RULE3] [RULE13]
    assign a_start = (st_r == ST_AXFR);
    assign a_addr  = addr_r; // [RULE5]
    assign a_tt    = tt_r;
    assign a_burst = burst_r;
    assign a_lanes = lanes;
    assign dbr_req = (st_r == ST_DARB);
    assign d_oe    = (st_r == ST_DXFR) && wr_r; // [RULE15]
    assign d_out   = wr_data;
    assign wr_pop  = beat_ok && wr_r;
    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign done     = done_r;
    assign err      = err_r;

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge core_clk or posedge rst) // [RULE1] [RULE2]
    begin
        if (rst)
        begin
            st_r       <= ST_IDLE;
            addr_r     <= '0;
            tt_r       <= 3'h0;
            nb_r       <= 4'h0;
            burst_r    <= 1'b0;
            wr_r       <= 1'b0;
            adonly_r   <= 1'b0;
            xpr_r      <= 1'b0;
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
            done_r     <= 1'b0;
            err_r      <= 1'b0;
        end
        else if (clk_en)
        begin
            st_r       <= st_nxt;
            rd_valid_r <= beat_ok && !wr_r; // [RULE15]
            if (beat_ok && !wr_r)
                rd_data_r <= d_in;
            done_r <= (st_r == ST_AEND && a_ack && !a_rerun && adonly_r)
                   || (beat_ok && blast && !xpr_r)
                   || (st_r == ST_XWAIT && x_reply);
            err_r  <= (st_r == ST_XWAIT && x_reply && !x_reply_ok)
                   || (st_r == ST_AXFR && !fits && !adonly_r && !xpr_r);
            if (take)
            begin
                // Bursts are forced to the sector base
                addr_r   <= req_burst ? {req_addr[31:STB_SECTOR_LSB], 5'h00}
                                      : req_addr; // [RULE9]
                tt_r     <= tt_sel;
                nb_r     <= req_nbytes;
                burst_r  <= req_burst && !req_dstore;
                wr_r     <= (req_kind == STB_RK_WRITE);
                adonly_r <= (req_kind == STB_RK_ADONLY);
                xpr_r    <= req_dstore;
            end
        end
    end
endmodule // stb_master

// file: hdl/stb_pkg.sv
// Package of constants and types for the split tenure bus master
// How it works
// [RULE1] All bus timing is referenced to the rising edge of one bus clock.
// [RULE2] Inputs are sampled and outputs launched on that same rising edge.
// [RULE3] The system arbiter grants ownership; no drive before a grant.
// [RULE4] The arbiter may park a master with a standing grant.
// [RULE5] Separate address path of 32 bits and data path of 64 bits.
// [RULE6] Coherence is tracked on aligned 32-byte sectors, MESI or MEI.
// [RULE7] Announce intent before reading a missing or writing a non-owned sector.
// [RULE8] A single beat moves contiguous bytes inside one aligned doubleword.
// [RULE9] A burst moves one aligned 32-byte block in beats.
// [RULE10] The data path can deliver one 8-byte beat every clock.
// [RULE11] Direct-store accesses use an extended protocol with a positive reply.
// [RULE12] Address and data tenures each run arbitration, transfer, termination.
// [RULE13] In address transfer the owner drives address and qualifiers.
// [RULE14] On address rerun the master abandons and requests the bus again.
// [RULE15] In data transfer the master samples on reads, drives on writes.
// [RULE16] The data tenure closes at termination unless retried, then repeats.
// [RULE17] Address-only transactions have an address tenure and no data tenure.
// [RULE18] A data tenure starts no earlier than its address transfer phase.
package stb_pkg;
    localparam int STB_ADDR_W     = 32;
    localparam int STB_DATA_W     = 64;
    localparam int STB_BE_W       = 8;
    localparam int STB_BURST_BEATS = 4;
    localparam int STB_BEAT_CNT_W = 2;
    localparam int STB_SECTOR_LSB = 5;
    localparam int STB_DW_LSB     = 3;
    localparam int STB_TT_W       = 3;
    localparam int STB_XADDR_W    = 32;
    // Transfer type codes on the qualifier lines
    localparam logic [2:0] STB_TT_READ   = 3'h0;
    localparam logic [2:0] STB_TT_WRITE  = 3'h1;
    localparam logic [2:0] STB_TT_RWITM  = 3'h2;
    localparam logic [2:0] STB_TT_ADONLY = 3'h3;
    localparam logic [2:0] STB_TT_XREAD  = 3'h4;
    localparam logic [2:0] STB_TT_XWRITE = 3'h5;
    localparam logic [2:0] STB_TT_CLAIM  = 3'h6;
    // Cache state of the sector the request aims at
    typedef enum logic [1:0] {
        STB_CS_INV = 2'h0,
        STB_CS_SHR = 2'h1,
        STB_CS_EXC = 2'h2,
        STB_CS_MOD = 2'h3
    } stb_cstate_t;
    // Request kinds from the core side
    typedef enum logic [1:0] {
        STB_RK_READ   = 2'h0,
        STB_RK_WRITE  = 2'h1,
        STB_RK_ADONLY = 2'h2
    } stb_rkind_t;
endpackage

// file: sim/stb_bus_model.sv
// Partner model: arbiter, memory and extended reply
`timescale 1ns/100ps
module stb_bus_model
    import stb_pkg::*;
(
    // Clock, reset and scenario controls
    input wire logic         core_clk, rst, slow, park, rr, dt, xok,
    // Address bus
    input wire logic         abr_req, a_start, a_oe, a_burst,
    input wire logic [31:0]  a_addr,
    input wire logic [2:0]   a_tt,
    output logic             abus_grant, a_ack, a_rerun,
    // Data bus
    input wire logic         dbr_req, d_oe,
    input wire logic [63:0]  d_out,
    output logic             dbus_grant, d_ack, d_retry, x_reply, x_reply_ok,
    output logic [63:0]      d_in, w_last
);
    logic        tick_r, dx_r, rru_r, dtu_r, bu_r, ext_r;
    logic [1:0]  beat_r;
    logic [31:0] ad_r;
    logic [63:0] hold_r;
    // Slow mode answers every other cycle only
    wire go = !slow || tick_r;
    assign abus_grant = (abr_req || park) && go;
    assign a_ack = a_oe && !a_start && go;
    assign a_rerun = a_ack && rr && !rru_r;
    assign dbus_grant = dbr_req && go;
    assign d_ack = dx_r && go;
    assign d_retry = d_ack && dt && !dtu_r;
    assign x_reply_ok = x_reply && xok;
    // Released lines show the inverse so stale data never matches
    assign d_in = d_ack ? {ad_r, 30'h0, beat_r} : ~hold_r;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            {tick_r, dx_r, rru_r, dtu_r, bu_r, ext_r, x_reply} <= 7'h00;
            {beat_r, ad_r, hold_r, w_last} <= 0;
        end
        else
        begin
            tick_r <= !tick_r;
            x_reply <= d_ack && !d_retry && ext_r && (!bu_r || &beat_r);
            rru_r <= rr && (rru_r || a_rerun);
            if (a_start)
            begin
                {ad_r, bu_r} <= {a_addr, a_burst};
                ext_r <= a_tt == STB_TT_XREAD || a_tt == STB_TT_XWRITE;
            end
            if (dbr_req && dbus_grant)
                {dx_r, beat_r} <= 3'h4;
            if (d_ack)
            begin
                hold_r <= d_in;
                if (d_oe)
                    w_last <= d_out;
                if (d_retry)
                    {dx_r, beat_r, dtu_r} <= 4'h1;
                else if (!bu_r || &beat_r)
                    dx_r <= 1'b0;
                else
                    beat_r <= beat_r + 2'h1;
            end
            if (!dt)
                dtu_r <= 1'b0;
        end
endmodule // stb_bus_model

// file: sim/stb_master_asserts.sv
// Checker of the bus master's tenure sequencing
`timescale 1ns/100ps
module stb_master_asserts
    import stb_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk, rst, clk_en,
    // Core side
    input wire logic        req_valid, req_ready, rd_valid, wr_pop, done,
    input wire logic [63:0] rd_data, d_in,
    // Address bus
    input wire logic        abr_req, abus_grant, a_start, a_oe, a_burst,
    input wire logic        a_ack, a_rerun,
    input wire logic [31:0] a_addr,
    input wire logic [2:0]  a_tt,
    // Data bus
    input wire logic        dbr_req, d_oe, d_ack, d_retry
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_take_arb: assert property (clk_en && req_valid && req_ready |=> abr_req)
        else $error("no address request after take");
    a_grant_first: assert property (a_start |-> $past(abr_req && abus_grant))
        else $error("address driven without grant");
    a_addr_hold: assert property (a_oe && !a_ack |=> a_oe && $stable(a_addr) && $stable(a_tt))
        else $error("address moved before termination");
    a_rerun_rereq: assert property (a_oe && a_ack && a_rerun |=> abr_req && !a_oe)
        else $error("no new request after rerun");
    a_addr_only: assert property (a_oe && a_ack && !a_rerun && a_tt == STB_TT_ADONLY |=> done && !dbr_req)
        else $error("data tenure after address only");
    a_data_order: assert property (dbr_req || d_oe |-> !a_oe)
        else $error("data tenure overlaps address");
    a_write_pop: assert property (wr_pop == (d_oe && d_ack && !d_retry))
        else $error("write beat not popped");
    a_read_data: assert property (rd_valid |-> rd_data == $past(d_in))
        else $error("read data not sampled");
    a_retry_rearb: assert property (d_oe && d_ack && d_retry |=> dbr_req && !d_oe)
        else $error("data tenure not repeated");
    a_burst_base: assert property (a_oe && a_burst |-> a_addr[4:0] == 5'h00)
        else $error("burst not sector aligned");
endmodule // stb_master_asserts
bind stb_master stb_master_asserts chk_u (.core_clk, .rst, .clk_en,
    .req_valid, .req_ready, .rd_valid, .wr_pop, .done, .rd_data, .d_in,
    .abr_req,
    .abus_grant, .a_start, .a_oe, .a_burst, .a_ack, .a_rerun, .a_addr,
    .a_tt, .dbr_req, .d_oe, .d_ack, .d_retry);

// file: sim/tb_top.sv
// Testbench for the split tenure bus master
`timescale 1ns/100ps
module tb_top;
    import stb_pkg::*;
    logic        core_clk = 0, rst = 1, req_valid = 0, req_burst = 0;
    logic        req_dstore = 0, req_mei = 0, slow = 0, park = 0, rr = 0;
    logic        dt = 0, xok = 1, clk_en = 1;
    stb_rkind_t  req_kind = STB_RK_READ;
    stb_cstate_t req_cstate = STB_CS_INV;
    logic [31:0] req_addr = 0, a_addr;
    logic [3:0]  req_nbytes = 1;
    logic [63:0] wr_data = 0, rd_data, d_out, d_in, w_last;
    logic [2:0]  a_tt;
    logic [7:0]  a_lanes;
    logic        req_ready, wr_pop, rd_valid, done, err, abr_req, abus_grant;
    logic        a_start, a_burst, a_oe, a_ack, a_rerun, dbr_req, dbus_grant;
    logic        d_oe, d_ack, d_retry, x_reply, x_reply_ok;
    int          failures = 0;
    int          tests_run = 0;
    initial forever #2 core_clk = ~core_clk;
    stb_master dut_u (.core_clk, .rst, .clk_en, .req_valid, .req_ready,
        .req_kind, .req_addr, .req_nbytes, .req_burst, .req_dstore,
        .req_cstate, .req_mei, .wr_data, .wr_pop, .rd_data, .rd_valid, .done,
        .err, .abr_req, .abus_grant, .a_start, .a_addr, .a_tt, .a_lanes,
        .a_burst, .a_oe, .a_ack, .a_rerun, .dbr_req, .dbus_grant, .d_out,
        .d_oe, .d_in, .d_ack, .d_retry, .x_reply, .x_reply_ok);
    stb_bus_model pm_u (.core_clk, .rst, .slow, .park, .rr, .dt, .xok,
        .abr_req, .a_start, .a_oe, .a_burst, .a_addr, .a_tt, .abus_grant,
        .a_ack, .a_rerun, .dbr_req, .d_oe, .d_out, .dbus_grant, .d_ack,
        .d_retry, .x_reply, .x_reply_ok, .d_in, .w_last);
    task automatic chk(input string nm, input logic [63:0] ex, got);
        tests_run++;
        if (ex !== got)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task results;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One whole transaction, judged beat by beat
    task automatic run(input logic [1:0] k, input logic [31:0] ad,
        input logic [3:0] nb, input logic bu, ds, mei, input logic [1:0] cs,
        input logic [2:0] tt, input logic e);
        logic [31:0] ea;
        int b, n, i;
        logic ge;
        logic [7:0] el;
        ea = bu ? {ad[31:5], 5'h00} : ad;
        // Expected byte lanes, one per byte of the doubleword
        for (i = 0; i < 8; i++)
            el[i] = bu || (i >= ad[2:0] && i < ad[2:0] + nb);
        {b, ge} = 0;
        {req_valid, req_addr, req_nbytes, req_burst} = {1'b1, ad, nb, bu};
        {req_dstore, req_mei, wr_data} = {ds, mei, ~ad, ad};
        req_kind = stb_rkind_t'(k);
        req_cstate = stb_cstate_t'(cs);
        @(negedge core_clk);
        req_valid = 0;
        for (n = 0; n < 100 && done !== 1'b1; n++)
        begin
            @(negedge core_clk);
            if (a_start === 1'b1)
            begin
                chk("address", ea, a_addr);
                chk("type", tt, a_tt);
                chk("lanes", el, a_lanes);
            end
            if (rd_valid === 1'b1)
                chk("read data", {ea, 30'h0, b[1:0]}, rd_data);
            b += (rd_valid === 1'b1);
            ge |= (err === 1'b1);
        end
        if (done !== 1'b1)
        begin
            failures++;
            results;
        end
        chk("error", e, ge);
        chk("beats", k == 2'h0 ? (bu ? 4 : 1) : 0, b);
        if (k == 2'h1)
            chk("write data", wr_data, w_last);
    endtask
    // A frozen clock enable must hold off a pending request
    task t_freeze;
        {clk_en, req_valid} = 2'b01;
        repeat (3) @(negedge core_clk);
        chk("frozen request", 0, abr_req);
        {clk_en, req_valid} = 2'b10;
        @(negedge core_clk);
    endtask
    task t_read;
        park = 1;
        run(0, 32'h1000_0010, 8, 0, 0, 0, 0, STB_TT_READ, 0);
        park = 0;
    endtask
    task t_burst;
        run(0, 32'h2000_0048, 1, 1, 0, 0, 0, STB_TT_READ, 0);
        slow = 1;
        run(0, 32'h2000_007F, 1, 1, 0, 0, 1, STB_TT_READ, 0);
        slow = 0;
    endtask
    task t_write;
        run(1, 32'h3000_0008, 8, 0, 0, 0, 1, STB_TT_RWITM, 0);
        run(1, 32'h3000_0010, 8, 0, 0, 0, 0, STB_TT_RWITM, 0);
        run(1, 32'h3000_0018, 8, 0, 0, 1, 1, STB_TT_WRITE, 0);
        run(1, 32'h3000_0030, 8, 0, 0, 1, 0, STB_TT_RWITM, 0);
        run(1, 32'h3000_0020, 8, 0, 0, 0, 2, STB_TT_WRITE, 0);
        run(1, 32'h3000_0028, 8, 0, 0, 0, 3, STB_TT_WRITE, 0);
    endtask
    task t_rerun_retry;
        rr = 1;
        run(0, 32'h4000_0000, 8, 0, 0, 0, 0, STB_TT_READ, 0);
        rr = 0;
        dt = 1;
        run(1, 32'h4000_0040, 8, 0, 0, 0, 3, STB_TT_WRITE, 0);
        dt = 0;
    endtask
    task t_other;
        run(2, 32'h5000_0000, 1, 0, 0, 0, 0, STB_TT_ADONLY, 0);
        run(0, 32'h6000_0000, 8, 0, 1, 0, 0, STB_TT_XREAD, 0);
        xok = 0;
        run(1, 32'h6000_0008, 8, 0, 1, 0, 3, STB_TT_XWRITE, 1);
        xok = 1;
        run(0, 32'h7000_0006, 4, 0, 0, 0, 0, STB_TT_READ, 1);
        run(0, 32'h7000_0006, 2, 0, 0, 0, 0, STB_TT_READ, 0);
    endtask
    initial
    begin
        repeat (6) @(negedge core_clk);
        rst = 0;
        t_freeze;
        t_read;
        t_burst;
        t_write;
        t_rerun_retry;
        t_other;
        results;
    end
endmodule // tb_top
